// >>> src/hpb_params.svh
`ifndef HPB_PARAMS_SVH
`define HPB_PARAMS_SVH
`define HPB_SEL_DATA 2'h0
`define HPB_SEL_MAILBOX 2'h1
`define HPB_SEL_ADDRESS 2'h2
`define HPB_SEL_STATUS 2'h3
`define HPB_DATA_W 16
`define HPB_ADDR_W 13
`define HPB_PTR_RESET 16'h0000
`define HPB_MBOX_RESET 16'h0000
`define HPB_ST_MODE_LSB 0
`define HPB_ST_DONE_BIT 2
`define HPB_ST_OUT_FULL_BIT 3
`define HPB_ST_IN_FULL_BIT 4
`define HPB_ST_PREFETCH_BIT 5
`define HPB_ST_BUF_FULL_BIT 6
`define HPB_ST_OVERRUN_BIT 7
`define HPB_BOOT_MS 3
`define HPB_CLK_KHZ 125000
`endif

// >>> src/hpb_pkg.sv
package hpb_pkg;
  typedef enum logic [1:0] {
    BOOT_PARALLEL,
    BOOT_FAST_SERIAL,
    BOOT_SPI_SLAVE,
    BOOT_STANDALONE
  } boot_mode_t;
  typedef enum logic [1:0] {BS_HOLD, BS_RUN, BS_DONE} boot_state_t;
  typedef enum logic {FS_IDLE, FS_WAIT} fetch_state_t;
endpackage : hpb_pkg

// >>> src/mem_if.sv
`timescale 1ns/100ps
`default_nettype none
interface mem_if #(parameter int AW = 13, parameter int DW = 16);
  logic req;
  logic we;
  logic ready;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  logic rvalid;
  modport requester(output req, we, addr, wdata, input ready, rdata, rvalid);
  modport memory(input req, we, addr, wdata, output ready, rdata, rvalid);
endinterface : mem_if
`default_nettype wire

// >>> src/pair_buffer.sv
`timescale 1ns/100ps
`default_nettype none
module pair_buffer #(
  parameter int W = 29
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  logic [W-1:0] slot0;
  logic [W-1:0] slot1;
  logic [1:0] count;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign out_data_o = slot0;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count <= 2'h0;
      slot0 <= '0;
      slot1 <= '0;
    end
    else
    begin
      count <= count + {1'b0, push} - {1'b0, pop};
      if (pop)
        slot0 <= (count == 2'h2) ? slot1 : in_data_i;
      else if (push && count == 2'h0)
        slot0 <= in_data_i;
      if (push && ((count == 2'h1 && !pop) || count == 2'h2))
        slot1 <= in_data_i;
    end
  end
  no_overflow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    count <= 2'h2) else $error("buffer holds more than two words");
endmodule : pair_buffer
`default_nettype wire

// >>> src/shared_ram.sv
`timescale 1ns/100ps
`default_nettype none
module shared_ram #(
  parameter int AW = 13
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Host port channel
  mem_if.memory host,
  // Internal processor channel, which has priority
  input wire logic cpu_req_i,
  input wire logic cpu_we_i,
  input wire logic [AW-1:0] cpu_addr_i,
  input wire logic [15:0] cpu_wdata_i,
  output logic [15:0] cpu_rdata_o,
  output logic cpu_rvalid_o
);
  logic [15:0] mem [0:(1<<AW)-1];
  wire host_go = host.req && !cpu_req_i;
  assign host.ready = !cpu_req_i;
  always_ff @(posedge clk_i)
  begin
    if (cpu_req_i && cpu_we_i)
      mem[cpu_addr_i] <= cpu_wdata_i;
    else if (host_go && host.we)
      mem[host.addr] <= host.wdata;
  end
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cpu_rdata_o <= 16'h0000;
      cpu_rvalid_o <= 1'b0;
      host.rdata <= 16'h0000;
      host.rvalid <= 1'b0;
    end
    else
    begin
      cpu_rvalid_o <= cpu_req_i && !cpu_we_i;
      host.rvalid <= host_go && !host.we;
      if (cpu_req_i && !cpu_we_i)
        cpu_rdata_o <= mem[cpu_addr_i];
      if (host_go && !host.we)
        host.rdata <= mem[host.addr];
    end
  end
endmodule : shared_ram
`default_nettype wire

// >>> src/host_port_boot_select.sv
// Behaviour
// RL1: Select lines pick data 00, mailbox 01, address pointer 10, status 11.
// RL2: Strobes are active low; an access is taken on the strobe's rising edge.
// RL3: Interrupt output flags a message waiting in the outgoing mailbox.
// RL4: Pointer advances after every data-port access; a data write refused by the full buffer leaves it unchanged.
// RL5: Data crosses the port on a 16-bit two-way bus.
// RL6: Mailbox can be written by either side to exchange messages.
// RL7: Data-port accesses reach memory at the pointer without the processor.
// RL8: Boot mode comes from the two strap pins at reset release.
// RL9: Strap 00 parallel port, 01 fast serial, 10 SPI slave, 11 standalone.
// RL10: Boot routine after a reset-pin event lasts at most 3 ms.
// RL11: Straps are sampled only during boot, then freed as ordinary pins.
// RL12: Non-standalone boot enters coprocessor mode with only that interface on.
// RL13: Test-mode pins may be driven as outputs up to 3 ms into boot.
// RL14: Host waits reset plus 3 ms of boot before loading code.
// RL15: Standalone boot turns the strap pins into outputs for the EEPROM.
// RL16: Standalone boot enables the debug UART pins.
// RL17: Standalone boot uses pin 29 as role id: high peripheral, low host.
// RL18: Standalone boot makes ports 1B, 2A and 2B USB peripherals.
// RL19: Standalone boot leaves every other pin an input.
// RL20: Reset input is held low at least sixteen reference clock cycles.
// RL21: Address-port write loads the pointer used by later data accesses.
`include "hpb_params.svh"
`timescale 1ns/100ps
`default_nettype none
module host_port_boot_select
  import hpb_pkg::*;
#(
  parameter int ADDR_W = `HPB_ADDR_W,
  parameter int unsigned BOOT_CYCLES = `HPB_BOOT_MS * `HPB_CLK_KHZ
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Host port pins
  input wire logic port_select_n_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic reg_select_hi_i,
  input wire logic reg_select_lo_i,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o,
  output logic data_oe_o,
  output logic mailbox_irq_out_o,
  // Reset pin, straps and role id
  input wire logic reset_in_n_i,
  input wire logic [1:0] boot_strap_i,
  input wire logic role_id_input_i,
  // Boot result and pin configuration
  output logic boot_done_o,
  output boot_mode_t boot_mode_o,
  output logic coproc_mode_o,
  output logic [2:0] iface_enable_o,
  output logic strap_pins_oe_o,
  output logic debug_uart_en_o,
  output logic dual_role_port_is_peripheral_o,
  output logic [2:0] usb_peripheral_ports_o,
  output logic test_pins_oe_o,
  // Internal processor side
  input wire logic cpu_req_i,
  input wire logic cpu_we_i,
  input wire logic [ADDR_W-1:0] cpu_addr_i,
  input wire logic [15:0] cpu_wdata_i,
  output logic [15:0] cpu_rdata_o,
  output logic cpu_rvalid_o,
  input wire logic cpu_mbox_wr_i,
  input wire logic [15:0] cpu_mbox_wdata_i,
  input wire logic cpu_mbox_take_i,
  output logic [15:0] cpu_mbox_o,
  output logic cpu_mbox_full_o
);
  localparam int SW = 25;
  localparam logic [SW-1:0] SYNC_IDLE = 25'h1c00000;
  localparam int BW = ADDR_W + 16;
  if (ADDR_W < 1 || ADDR_W > 16 || BOOT_CYCLES < 1)
  begin : g_check
    $error("host_port_boot_select: unsupported ADDR_W or BOOT_CYCLES");
  end
  // Every pin is asynchronous to clk_i, so all of them pass two flops.
  // The reset pin idles low in the flops, so a pin still held low starts no boot.
  logic [SW-1:0] sync1, sync2, sync3;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1 <= SYNC_IDLE;
      sync2 <= SYNC_IDLE;
      sync3 <= SYNC_IDLE;
    end
    else
    begin
      sync1 <= {port_select_n_i, read_strobe_n_i, write_strobe_n_i, reg_select_hi_i,
                reg_select_lo_i, data_i, reset_in_n_i, boot_strap_i, role_id_input_i};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  wire cs_n_now = sync2[24];
  wire rd_n_now = sync2[23];
  wire wr_n_now = sync2[22];
  wire cs_n_old = sync3[24];
  wire rd_n_old = sync3[23];
  wire wr_n_old = sync3[22];
  wire [1:0] sel_now = sync2[21:20];
  wire [1:0] sel_old = sync3[21:20];
  wire [15:0] wdata_old = sync3[19:4];
  wire reset_pin_n = sync2[3];
  wire [1:0] strap_now = sync2[2:1];
  wire role_id_now = sync2[0];
  // Boot sequencing.
  boot_state_t boot_state;
  logic [31:0] boot_timer;
  boot_mode_t boot_mode;
  wire boot_run_end = (boot_timer == BOOT_CYCLES - 1);
  wire standalone = (boot_mode == BOOT_STANDALONE);
  wire boot_done = (boot_state == BS_DONE);
  wire host_enabled = boot_done && (boot_mode == BOOT_PARALLEL); // RL12
  // A short glitch on the reset pin is not filtered; the driver must hold it long enough.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      boot_state <= BS_HOLD;
      boot_timer <= 32'h0000_0000;
      boot_mode <= BOOT_PARALLEL;
    end
    else if (!reset_pin_n) // RL20
    begin
      boot_state <= BS_HOLD;
      boot_timer <= 32'h0000_0000;
    end
    else
    begin
      case (boot_state)
        BS_HOLD:
        begin
          boot_state <= BS_RUN;
          boot_mode <= boot_mode_t'(strap_now); // RL8 RL9 RL11
        end
        BS_RUN:
        begin
          if (boot_run_end)
            boot_state <= BS_DONE;
          else
            boot_timer <= boot_timer + 32'h0000_0001; // RL10
        end
        BS_DONE: boot_timer <= boot_timer;
        default: boot_state <= BS_HOLD;
      endcase
    end
  end
  // Host strobe decode, taken when the strobe returns high.
  wire sel_active = host_enabled && !cs_n_old;
  wire rd_take = sel_active && !rd_n_old && rd_n_now; // RL2
  wire wr_take = sel_active && !wr_n_old && wr_n_now; // RL2
  wire wr_data = wr_take && sel_old == `HPB_SEL_DATA; // RL1
  wire wr_mbox = wr_take && sel_old == `HPB_SEL_MAILBOX;
  wire wr_addr = wr_take && sel_old == `HPB_SEL_ADDRESS;
  wire rd_data = rd_take && sel_old == `HPB_SEL_DATA;
  wire rd_mbox = rd_take && sel_old == `HPB_SEL_MAILBOX;
  wire rd_stat = rd_take && sel_old == `HPB_SEL_STATUS;
  // Write path into memory through the two-entry buffer.
  mem_if #(.AW(ADDR_W), .DW(16)) mif ();
  logic [15:0] pointer;
  logic buf_in_ready, buf_out_valid;
  logic [BW-1:0] buf_out_data;
  wire buf_push = wr_data && buf_in_ready;
  wire buf_pop = buf_out_valid && mif.ready;
  pair_buffer #(.W(BW)) u_wbuf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(wr_data),
    .in_ready_o(buf_in_ready),
    .in_data_i({pointer[ADDR_W-1:0], wdata_old}),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_pop),
    .out_data_o(buf_out_data)
  );
  // Read prefetch: fetched only after queued writes drained, so reads see them.
  fetch_state_t fetch_state;
  logic fetch_pending;
  logic [15:0] prefetch;
  wire fetch_go = fetch_pending && !buf_out_valid && fetch_state == FS_IDLE;
  wire fetch_issue = fetch_go && mif.ready;
  wire ptr_moved = wr_addr || buf_push || rd_data;
  assign mif.req = buf_out_valid || fetch_go; // RL7
  assign mif.we = buf_out_valid;
  assign mif.addr = buf_out_valid ? buf_out_data[BW-1:16] : pointer[ADDR_W-1:0];
  assign mif.wdata = buf_out_data[15:0];
  shared_ram #(.AW(ADDR_W)) u_ram (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .host(mif),
    .cpu_req_i(cpu_req_i),
    .cpu_we_i(cpu_we_i),
    .cpu_addr_i(cpu_addr_i),
    .cpu_wdata_i(cpu_wdata_i),
    .cpu_rdata_o(cpu_rdata_o),
    .cpu_rvalid_o(cpu_rvalid_o)
  );
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pointer <= `HPB_PTR_RESET;
      fetch_pending <= 1'b1;
      fetch_state <= FS_IDLE;
      prefetch <= 16'h0000;
    end
    else
    begin
      if (wr_addr)
        pointer <= wdata_old; // RL21
      else if (buf_push || rd_data)
        pointer <= pointer + 16'h0001; // RL4
      fetch_pending <= ptr_moved || (fetch_pending && !fetch_issue);
      if (fetch_issue)
        fetch_state <= FS_WAIT;
      else if (mif.rvalid)
        fetch_state <= FS_IDLE;
      if (mif.rvalid)
        prefetch <= mif.rdata;
    end
  end
  // Mailbox in both directions; a new message wins over a clear in the same cycle.
  logic [15:0] mbox_out, mbox_in;
  logic mbox_out_full, mbox_in_full, overrun;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mbox_out <= `HPB_MBOX_RESET;
      mbox_in <= `HPB_MBOX_RESET;
      mbox_out_full <= 1'b0;
      mbox_in_full <= 1'b0;
      overrun <= 1'b0;
    end
    else
    begin
      if (cpu_mbox_wr_i)
        mbox_out <= cpu_mbox_wdata_i; // RL6
      if (wr_mbox)
        mbox_in <= wdata_old; // RL6
      mbox_out_full <= cpu_mbox_wr_i || (mbox_out_full && !rd_mbox); // RL3
      mbox_in_full <= wr_mbox || (mbox_in_full && !cpu_mbox_take_i);
      overrun <= (wr_data && !buf_in_ready) || (overrun && !rd_stat);
    end
  end
  wire [15:0] status_word = {8'h00, overrun, !buf_in_ready,
                             !fetch_pending && fetch_state == FS_IDLE,
                             mbox_in_full, mbox_out_full, boot_done, boot_mode};
  logic [15:0] read_mux;
  always_comb
  begin
    case (sel_now) // RL1
      `HPB_SEL_DATA: read_mux = prefetch;
      `HPB_SEL_MAILBOX: read_mux = mbox_out;
      `HPB_SEL_ADDRESS: read_mux = pointer;
      default: read_mux = status_word;
    endcase
  end
  // Registered pin and configuration outputs.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      data_o <= 16'h0000;
      data_oe_o <= 1'b0;
      mailbox_irq_out_o <= 1'b0;
      boot_done_o <= 1'b0;
      boot_mode_o <= BOOT_PARALLEL;
      coproc_mode_o <= 1'b0;
      iface_enable_o <= 3'h0;
      strap_pins_oe_o <= 1'b0;
      debug_uart_en_o <= 1'b0;
      dual_role_port_is_peripheral_o <= 1'b0;
      usb_peripheral_ports_o <= 3'h0;
      test_pins_oe_o <= 1'b0;
      cpu_mbox_o <= `HPB_MBOX_RESET;
      cpu_mbox_full_o <= 1'b0;
    end
    else
    begin
      data_o <= read_mux; // RL5
      data_oe_o <= host_enabled && !cs_n_now && !rd_n_now; // RL5
      mailbox_irq_out_o <= mbox_out_full; // RL3
      boot_done_o <= boot_done;
      boot_mode_o <= boot_mode;
      coproc_mode_o <= boot_done && !standalone; // RL12
      for (int i = 0; i < 3; i++)
        iface_enable_o[i] <= boot_done && boot_mode == boot_mode_t'(i); // RL12
      strap_pins_oe_o <= boot_done && standalone; // RL15
      debug_uart_en_o <= boot_done && standalone; // RL16
      dual_role_port_is_peripheral_o <= boot_done && standalone && role_id_now; // RL17
      usb_peripheral_ports_o <= {3{boot_done && standalone}}; // RL18
      test_pins_oe_o <= (boot_state == BS_RUN) && !boot_run_end; // RL13 RL19
      cpu_mbox_o <= mbox_in;
      cpu_mbox_full_o <= mbox_in_full;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  addr_load_a: assert property (wr_addr |=> pointer == $past(wdata_old)) // RL21
    else $error("pointer not loaded by address write");
  mbox_sel_a: assert property (wr_mbox |=> ##1 cpu_mbox_o == $past(wdata_old, 2)) // RL1
    else $error("mailbox write did not reach processor");
  strobe_low_a: assert property (data_oe_o |-> $past(!rd_n_now && !cs_n_now)) // RL2
    else $error("data driven without active read strobe");
  irq_raise_a: assert property (cpu_mbox_wr_i |=> ##1 mailbox_irq_out_o) // RL3
    else $error("mailbox interrupt not raised");
  ptr_step_a: assert property ((buf_push || rd_data) && !wr_addr |=> // RL4
    pointer == $past(pointer) + 16'h0001)
    else $error("pointer did not advance");
  drain_write_a: assert property (buf_pop |=> // RL7
    u_ram.mem[$past(mif.addr)] == $past(mif.wdata))
    else $error("queued write did not reach memory");
  strap_capture_a: assert property (boot_state == BS_HOLD && reset_pin_n |=> // RL8
    boot_mode == boot_mode_t'($past(strap_now)))
    else $error("boot mode not taken from straps");
  boot_bound_a: assert property (boot_timer < BOOT_CYCLES) // RL10
    else $error("boot routine overran its limit");
  host_gate_a: assert property (data_oe_o |-> $past(host_enabled)) // RL12
    else $error("host port active outside parallel coprocessor mode");
  strap_drive_a: assert property (strap_pins_oe_o |-> boot_mode_o == BOOT_STANDALONE) // RL15
    else $error("strap pins driven outside standalone mode");
  test_window_a: assert property (test_pins_oe_o |-> $past(boot_state == BS_RUN)) // RL13
    else $error("test pins driven outside boot");
  data_read_c: cover property (rd_data ##[1:20] mif.rvalid);
  mbox_round_c: cover property (cpu_mbox_wr_i ##[1:50] rd_mbox);
  standalone_c: cover property (strap_pins_oe_o && debug_uart_en_o);
  buf_full_c: cover property (!buf_in_ready && wr_data);
endmodule : host_port_boot_select
`default_nettype wire

// >>> sim/host_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_cpu_model (
  // Clock
  input wire logic clk_i,
  // Strobes and select lines toward the device
  output logic port_select_n_o,
  output logic read_strobe_n_o,
  output logic write_strobe_n_o,
  output logic [1:0] reg_select_o,
  // Shared data bus
  output logic [15:0] bus_level_o,
  input wire logic [15:0] dev_data_i,
  input wire logic dev_oe_i
);
  logic drive;
  logic [15:0] drive_val;

  // A floating bus shows the inverse of the last host word, so stale data never matches.
  assign bus_level_o = drive ? drive_val : (dev_oe_i ? dev_data_i : ~drive_val);

  initial
  begin
    port_select_n_o = 1'b1;
    read_strobe_n_o = 1'b1;
    write_strobe_n_o = 1'b1;
    reg_select_o = 2'h0;
    drive = 1'b0;
    drive_val = 16'h0000;
  end

  // Select and data are set together with the strobe's fall and stay put until well after it rises.
  task automatic access(input logic we, input logic [1:0] sel, input logic [15:0] wdata,
                        output logic [15:0] rdata);
    @(posedge clk_i);
    #1;
    port_select_n_o = 1'b0;
    reg_select_o = sel;
    drive = we;
    drive_val = wdata;
    read_strobe_n_o = we;
    write_strobe_n_o = !we;
    repeat (5) @(posedge clk_i);
    #1;
    rdata = bus_level_o;
    read_strobe_n_o = 1'b1;
    write_strobe_n_o = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    port_select_n_o = 1'b1;
    drive = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : access
endmodule : host_cpu_model
`default_nettype wire

// >>> sim/host_port_boot_select_tb.sv
`include "hpb_params.svh"
`timescale 1ns/100ps
`default_nettype none
module host_port_boot_select_tb
  import hpb_pkg::*;
;
  typedef struct packed {
    logic [1:0] strap;
    logic role;
    logic [11:0] pins;
  } boot_row_t;

  logic clk_i, rst_i, reset_in_n_i, role_id_input_i;
  logic cpu_req_i, cpu_we_i, cpu_mbox_wr_i, cpu_mbox_take_i;
  logic [1:0] boot_strap_i, reg_select;
  logic [12:0] cpu_addr_i;
  logic [15:0] cpu_wdata_i, cpu_mbox_wdata_i, bus_level, data_o, cpu_rdata_o, cpu_mbox_o, seen;
  logic cs_n, rd_n, wr_n, data_oe_o, mailbox_irq_out_o, boot_done_o, coproc_mode_o, periph;
  logic strap_pins_oe_o, debug_uart_en_o, test_pins_oe_o, cpu_rvalid_o, cpu_mbox_full_o;
  logic [2:0] iface_enable_o, usb_peripheral_ports_o;
  logic [11:0] pins;
  boot_mode_t boot_mode_o;
  int failures, samples_checked;
  boot_row_t rows [5];
  logic [15:0] words [3];

  assign pins = {boot_mode_o, coproc_mode_o, iface_enable_o, strap_pins_oe_o, debug_uart_en_o,
                 periph, usb_peripheral_ports_o};

  host_port_boot_select #(.BOOT_CYCLES(20)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .port_select_n_i(cs_n), .read_strobe_n_i(rd_n),
    .write_strobe_n_i(wr_n), .reg_select_hi_i(reg_select[1]), .reg_select_lo_i(reg_select[0]),
    .data_i(bus_level), .data_o(data_o), .data_oe_o(data_oe_o),
    .mailbox_irq_out_o(mailbox_irq_out_o), .reset_in_n_i(reset_in_n_i),
    .boot_strap_i(boot_strap_i), .role_id_input_i(role_id_input_i), .boot_done_o(boot_done_o),
    .boot_mode_o(boot_mode_o), .coproc_mode_o(coproc_mode_o), .iface_enable_o(iface_enable_o),
    .strap_pins_oe_o(strap_pins_oe_o), .debug_uart_en_o(debug_uart_en_o),
    .dual_role_port_is_peripheral_o(periph), .usb_peripheral_ports_o(usb_peripheral_ports_o),
    .test_pins_oe_o(test_pins_oe_o), .cpu_req_i(cpu_req_i), .cpu_we_i(cpu_we_i),
    .cpu_addr_i(cpu_addr_i), .cpu_wdata_i(cpu_wdata_i), .cpu_rdata_o(cpu_rdata_o),
    .cpu_rvalid_o(cpu_rvalid_o), .cpu_mbox_wr_i(cpu_mbox_wr_i),
    .cpu_mbox_wdata_i(cpu_mbox_wdata_i), .cpu_mbox_take_i(cpu_mbox_take_i),
    .cpu_mbox_o(cpu_mbox_o), .cpu_mbox_full_o(cpu_mbox_full_o));

  host_cpu_model host_u (
    .clk_i(clk_i), .port_select_n_o(cs_n), .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n),
    .reg_select_o(reg_select), .bus_level_o(bus_level), .dev_data_i(data_o),
    .dev_oe_i(data_oe_o));

  always #4 clk_i = ~clk_i;

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic hacc(input logic we, input logic [1:0] sel, input logic [15:0] wd);
    host_u.access(we, sel, wd, seen);
  endtask : hacc

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  // The straps are held through the boot run and flipped only once it is over.
  task automatic boot(input boot_row_t r);
    int n;
    tick(1);
    boot_strap_i = r.strap;
    role_id_input_i = r.role;
    reset_in_n_i = 1'b0;
    tick(20);
    reset_in_n_i = 1'b1;
    tick(8);
    check("test pin drive", {31'h0, test_pins_oe_o}, 32'h1);
    check("done early", {31'h0, boot_done_o}, 32'h0);
    n = 0;
    while (boot_done_o !== 1'b1 && n < 24)
    begin
      tick(1);
      n++;
    end
    check("boot done", {31'h0, boot_done_o}, 32'h1);
    check("pin setup", {20'h0, pins}, {20'h0, r.pins});
    check("test pins off", {31'h0, test_pins_oe_o}, 32'h0);
    boot_strap_i = ~r.strap;
    tick(4);
    check("straps freed", {20'h0, pins}, {20'h0, r.pins});
  endtask : boot

  task automatic wait_prefetch();
    seen = 16'h0000;
    for (int i = 0; i < 8 && seen[5] !== 1'b1; i++) hacc(1'b0, `HPB_SEL_STATUS, 16'h0000);
    check("prefetch valid", {31'h0, seen[5]}, 32'h1);
  endtask : wait_prefetch

  initial
  begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    reset_in_n_i = 1'b0;
    boot_strap_i = 2'h0;
    role_id_input_i = 1'b0;
    cpu_req_i = 1'b0;
    cpu_we_i = 1'b0;
    cpu_addr_i = 13'h0000;
    cpu_wdata_i = 16'h0000;
    cpu_mbox_wr_i = 1'b0;
    cpu_mbox_wdata_i = 16'h0000;
    cpu_mbox_take_i = 1'b0;
    failures = 0;
    samples_checked = 0;
    rows = '{'{2'h3, 1'b1, 12'hc3f}, '{2'h3, 1'b0, 12'hc37}, '{2'h1, 1'b0, 12'h680},
             '{2'h2, 1'b1, 12'hb00}, '{2'h0, 1'b1, 12'h240}};
    words = '{16'h1234, 16'ha55a, 16'h0f0f};
    tick(8);
    check("done in reset", {31'h0, boot_done_o}, 32'h0);
    check("irq in reset", {31'h0, mailbox_irq_out_o}, 32'h0);
    rst_i = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      boot(rows[i]);
      // Only the parallel boot may let the host reach the mailbox.
      hacc(1'b1, `HPB_SEL_MAILBOX, 16'hc3a5);
      check("mailbox in", {31'h0, cpu_mbox_full_o}, {31'h0, rows[i].strap == 2'h0});
      $display("boot row %0d done", i);
    end
    check("mailbox in value", {16'h0, cpu_mbox_o}, 32'hc3a5);
    cpu_mbox_take_i = 1'b1;
    tick(1);
    cpu_mbox_take_i = 1'b0;
    tick(3);
    check("mailbox taken", {31'h0, cpu_mbox_full_o}, 32'h0);
    hacc(1'b0, `HPB_SEL_STATUS, 16'h0000);
    check("status", {16'h0, seen}, 32'h0024);
    hacc(1'b1, `HPB_SEL_ADDRESS, 16'h0010);
    for (int k = 0; k < 3; k++) hacc(1'b1, `HPB_SEL_DATA, words[k]);
    hacc(1'b1, `HPB_SEL_ADDRESS, 16'h0010);
    for (int k = 0; k < 3; k++)
    begin
      wait_prefetch();
      hacc(1'b0, `HPB_SEL_DATA, 16'h0000);
      check("data read", {16'h0, seen}, {16'h0, words[k]});
    end
    hacc(1'b0, `HPB_SEL_ADDRESS, 16'h0000);
    check("pointer advanced", {16'h0, seen}, 32'h0013);
    $display("block transfer done");
    cpu_addr_i = 13'h0011;
    cpu_req_i = 1'b1;
    tick(1);
    cpu_req_i = 1'b0;
    for (int k = 0; k < 3 && cpu_rvalid_o !== 1'b1; k++) tick(1);
    check("cpu rvalid", {31'h0, cpu_rvalid_o}, 32'h1);
    check("cpu rdata", {16'h0, cpu_rdata_o}, {16'h0, words[1]});
    cpu_mbox_wdata_i = 16'h5a3c;
    cpu_mbox_wr_i = 1'b1;
    tick(1);
    cpu_mbox_wr_i = 1'b0;
    tick(3);
    check("irq raised", {31'h0, mailbox_irq_out_o}, 32'h1);
    hacc(1'b0, `HPB_SEL_MAILBOX, 16'h0000);
    check("mailbox out", {16'h0, seen}, 32'h5a3c);
    check("irq cleared", {31'h0, mailbox_irq_out_o}, 32'h0);
    $display("mailbox test done");
    // A busy processor port stalls the drain, so the third write meets a full buffer.
    hacc(1'b1, `HPB_SEL_ADDRESS, 16'h0020);
    cpu_req_i = 1'b1;
    for (int k = 0; k < 3; k++) hacc(1'b1, `HPB_SEL_DATA, words[k]);
    hacc(1'b0, `HPB_SEL_STATUS, 16'h0000);
    check("overrun status", {16'h0, seen}, 32'h00c4);
    cpu_req_i = 1'b0;
    hacc(1'b0, `HPB_SEL_ADDRESS, 16'h0000);
    check("dropped write", {16'h0, seen}, 32'h0022);
    hacc(1'b0, `HPB_SEL_STATUS, 16'h0000);
    check("overrun cleared", {16'h0, seen}, 32'h0024);
    $display("overrun test done");
    close_out();
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    failures++;
    $display("[FAIL] watchdog expected finish seen timeout");
    close_out();
  end
endmodule : host_port_boot_select_tb
`default_nettype wire
